// file: pcwc_pkg.sv
// Behaviour
// - Offsets 0,2000,6000,8000,10000,20000,30000 code as 00,80,90,20,a0,50,f0.
// - Device rebuilds full number as number field plus offset of page code.
// - 8-bit value sits in low word bits 7:0, bits 15:8 zero.
// - 16-bit value fills low word; 32-bit value spans high and low words.
// - Third word carries value bits 31:16, fourth word bits 15:0.
// - Connector: high word source number, low 15:10 object, 9:0 index.
// - Request code in first word bits 15:12; code 6 reads an array element.
// - Request code 7 changes a word-sized value, array element or plain.
// - Word order: identifier, index, high value, low value.
// - Unexecutable request answers code 7 with error number in the last word.
// - Reply code 1 for a word value, code 2 for a double word.
package pcwc_pkg;
   // Byte offsets of the register words.
   localparam logic [7:0] PCWC_REQ_ID   = 8'h00;
   localparam logic [7:0] PCWC_REQ_IDX  = 8'h04;
   localparam logic [7:0] PCWC_REQ_VHI  = 8'h08;
   localparam logic [7:0] PCWC_REQ_VLO  = 8'h0c;
   localparam logic [7:0] PCWC_DEC_CMD  = 8'h10;
   localparam logic [7:0] PCWC_DEC_PAR  = 8'h14;
   localparam logic [7:0] PCWC_DEC_VAL  = 8'h18;
   localparam logic [7:0] PCWC_RSP_CMD  = 8'h20;
   localparam logic [7:0] PCWC_RSP_VAL  = 8'h24;
   localparam logic [7:0] PCWC_RSP_W01  = 8'h28;
   localparam logic [7:0] PCWC_RSP_W23  = 8'h2c;
   localparam logic [15:0] PCWC_WORD_RST = 16'h0000;
   // Request and response codes.
   localparam logic [3:0] PCWC_RQ_READ_ARR  = 4'h6;
   localparam logic [3:0] PCWC_RQ_WRITE_WRD = 4'h7;
   localparam logic [3:0] PCWC_RC_WORD      = 4'h1;
   localparam logic [3:0] PCWC_RC_DWORD     = 4'h2;
   localparam logic [3:0] PCWC_RC_ERROR     = 4'h7;
   localparam logic [15:0] PCWC_ERR_NO_PARAM = 16'h0000;
   localparam logic [5:0] PCWC_DRIVE_OBJ    = 6'h3f;
   // Response kinds and value sizes in the response command word.
   localparam logic [1:0] PCWC_KIND_WORD  = 2'h0;
   localparam logic [1:0] PCWC_KIND_DWORD = 2'h1;
   localparam logic [1:0] PCWC_KIND_ERROR = 2'h2;
   localparam logic [1:0] PCWC_SIZE_8     = 2'h0;
   localparam logic [1:0] PCWC_SIZE_16    = 2'h1;
   localparam logic [1:0] PCWC_SIZE_32    = 2'h2;
   // Page index codes and their offsets.
   localparam logic [7:0]  PCWC_PG_0     = 8'h00;
   localparam logic [7:0]  PCWC_PG_2000  = 8'h80;
   localparam logic [7:0]  PCWC_PG_6000  = 8'h90;
   localparam logic [7:0]  PCWC_PG_8000  = 8'h20;
   localparam logic [7:0]  PCWC_PG_10000 = 8'ha0;
   localparam logic [7:0]  PCWC_PG_20000 = 8'h50;
   localparam logic [7:0]  PCWC_PG_30000 = 8'hf0;
   localparam logic [14:0] PCWC_OFF_2000  = 15'd2000;
   localparam logic [14:0] PCWC_OFF_6000  = 15'd6000;
   localparam logic [14:0] PCWC_OFF_8000  = 15'd8000;
   localparam logic [14:0] PCWC_OFF_10000 = 15'd10000;
   localparam logic [14:0] PCWC_OFF_20000 = 15'd20000;
   localparam logic [14:0] PCWC_OFF_30000 = 15'd30000;

   // Returns {valid, offset} for a page index code.
   function automatic logic [15:0] pcwc_page_offset(input logic [7:0] pg);
      case (pg)
         PCWC_PG_0:     return {1'b1, 15'd0};
         PCWC_PG_2000:  return {1'b1, PCWC_OFF_2000};
         PCWC_PG_6000:  return {1'b1, PCWC_OFF_6000};
         PCWC_PG_8000:  return {1'b1, PCWC_OFF_8000};
         PCWC_PG_10000: return {1'b1, PCWC_OFF_10000};
         PCWC_PG_20000: return {1'b1, PCWC_OFF_20000};
         PCWC_PG_30000: return {1'b1, PCWC_OFF_30000};
         default:       return 16'h0000;
      endcase
   endfunction
endpackage

// file: pcwc_codec.sv
`timescale 1ns/1ps
module pcwc_codec
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   import pcwc_pkg::*;

   logic [7:0]  addr_q;
   logic        wr_q;
   logic        rd_q;
   logic [15:0] id_q;
   logic [15:0] idx_q;
   logic [15:0] vhi_q;
   logic [15:0] vlo_q;
   logic [14:0] dec_par_q;
   logic        dec_err_q;
   logic [3:0]  dec_code_q;
   logic [7:0]  dec_sub_q;
   logic        dec_rd_q;
   logic        dec_wr_q;
   logic        dec_obj_ok_q;
   logic [31:0] dec_val_q;
   logic [31:0] rsp_val_q;
   logic [15:0] rsp_w0_q;
   logic [15:0] rsp_w1_q;
   logic [15:0] rsp_w2_q;
   logic [15:0] rsp_w3_q;
   logic        dec_go;
   logic        rsp_go;
   logic [15:0] pg_info;
   logic        pg_ok;
   logic [14:0] full_num;
   logic [1:0]  rsp_kind;
   logic [1:0]  rsp_size;
   logic [15:0] rsp_err;

   // The slave never stalls and never errors, so every transfer takes
   // one address cycle and one data cycle.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture; writes are acted on only as full words, reads at any size.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_q <= 8'h00;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end
      else if (hready)
      begin
         addr_q <= {haddr[7:2], 2'b00};
         wr_q   <= hsel & htrans[1] & hwrite & (hsize == 3'h2);
         rd_q   <= hsel & htrans[1] & ~hwrite;
      end
   end

   assign dec_go   = wr_q & (addr_q == PCWC_DEC_CMD) & hwdata[0];
   assign rsp_go   = wr_q & (addr_q == PCWC_RSP_CMD);
   assign rsp_kind = hwdata[1:0];
   assign rsp_size = hwdata[3:2];
   assign rsp_err  = {8'h00, hwdata[15:8]};

   // Request words as received, kept in channel order.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         id_q  <= PCWC_WORD_RST;
         idx_q <= PCWC_WORD_RST;
         vhi_q <= PCWC_WORD_RST;
         vlo_q <= PCWC_WORD_RST;
      end
      else if (wr_q)
      begin
         // Word order identifier, index, high value, low value.
         if (addr_q == PCWC_REQ_ID)  id_q  <= hwdata[15:0];
         if (addr_q == PCWC_REQ_IDX) idx_q <= hwdata[15:0];
         if (addr_q == PCWC_REQ_VHI) vhi_q <= hwdata[15:0];
         if (addr_q == PCWC_REQ_VLO) vlo_q <= hwdata[15:0];
      end
   end

   // Page code lookup and number rebuild; bit 11 is not looked at.
   assign pg_info  = pcwc_page_offset(idx_q[15:8]);
   assign pg_ok    = pg_info[15];
   assign full_num = {4'h0, id_q[10:0]} + pg_info[14:0];

   // Decode snapshot, taken when software asks for it.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dec_par_q    <= 15'h0000;
         dec_err_q    <= 1'b0;
         dec_code_q   <= 4'h0;
         dec_sub_q    <= 8'h00;
         dec_rd_q     <= 1'b0;
         dec_wr_q     <= 1'b0;
         dec_obj_ok_q <= 1'b0;
         dec_val_q    <= 32'h0000_0000;
      end
      else if (dec_go)
      begin
         dec_par_q    <= pg_ok ? full_num : 15'h0000;
         dec_err_q    <= ~pg_ok;
         dec_code_q   <= id_q[15:12];
         dec_sub_q    <= idx_q[7:0];
         dec_rd_q     <= id_q[15:12] == PCWC_RQ_READ_ARR;
         dec_wr_q     <= id_q[15:12] == PCWC_RQ_WRITE_WRD;
         // A connector value is flagged when it carries the fixed object code; the value is kept either way.
         dec_obj_ok_q <= vlo_q[15:10] == PCWC_DRIVE_OBJ;
         // Value words of a read are ignored rather than trusted.
         if (id_q[15:12] == PCWC_RQ_READ_ARR)
            dec_val_q <= 32'h0000_0000;
         else
            dec_val_q <= {vhi_q, vlo_q};
      end
   end

   // Response value as loaded by software.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rsp_val_q <= 32'h0000_0000;
      else if (wr_q && addr_q == PCWC_RSP_VAL)
         rsp_val_q <= hwdata;
   end

   // Response build; a bad page code forces the error answer so software
   // cannot return data for a parameter that does not exist.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rsp_w0_q <= PCWC_WORD_RST;
         rsp_w1_q <= PCWC_WORD_RST;
         rsp_w2_q <= PCWC_WORD_RST;
         rsp_w3_q <= PCWC_WORD_RST;
      end
      else if (rsp_go)
      begin
         rsp_w1_q <= idx_q;
         if (dec_err_q || rsp_kind == PCWC_KIND_ERROR)
         begin
            rsp_w0_q <= {PCWC_RC_ERROR, 1'b0, id_q[10:0]};
            rsp_w2_q <= 16'h0000;
            rsp_w3_q <= dec_err_q ? PCWC_ERR_NO_PARAM : rsp_err;
         end
         else if (rsp_kind == PCWC_KIND_DWORD || rsp_size == PCWC_SIZE_32)
         begin
            rsp_w0_q <= {PCWC_RC_DWORD, 1'b0, id_q[10:0]};
            rsp_w2_q <= rsp_val_q[31:16];
            rsp_w3_q <= rsp_val_q[15:0];
         end
         else
         begin
            rsp_w0_q <= {PCWC_RC_WORD, 1'b0, id_q[10:0]};
            rsp_w2_q <= 16'h0000;
            if (rsp_size == PCWC_SIZE_8)
               rsp_w3_q <= {8'h00, rsp_val_q[7:0]};
            else
               rsp_w3_q <= rsp_val_q[15:0];
         end
      end
   end

   // Read mux over flip-flops; unmapped offsets read as zero.
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (rd_q)
      begin
         case (addr_q)
            PCWC_REQ_ID:  hrdata = {16'h0000, id_q};
            PCWC_REQ_IDX: hrdata = {16'h0000, idx_q};
            PCWC_REQ_VHI: hrdata = {16'h0000, vhi_q};
            PCWC_REQ_VLO: hrdata = {16'h0000, vlo_q};
            PCWC_DEC_PAR: hrdata = {1'b0, dec_obj_ok_q, dec_wr_q, dec_rd_q,
                                    dec_sub_q, dec_code_q, dec_err_q,
                                    dec_par_q};
            PCWC_DEC_VAL: hrdata = dec_val_q;
            PCWC_RSP_VAL: hrdata = rsp_val_q;
            PCWC_RSP_W01: hrdata = {rsp_w1_q, rsp_w0_q};
            PCWC_RSP_W23: hrdata = {rsp_w2_q, rsp_w3_q};
            default:      hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Checks on decode and response build.
   property p_rebuild;
      @(posedge hclk) disable iff (!hresetn)
      dec_go && pg_ok |=> dec_par_q == $past(full_num) && !dec_err_q;
   endproperty
   a_rebuild: assert property (p_rebuild)
      else $error("Rebuilt parameter number is wrong.");

   property p_page90;
      @(posedge hclk) disable iff (!hresetn)
      dec_go && idx_q[15:8] == 8'h90
      |=> dec_par_q == {4'h0, $past(id_q[10:0])} + 15'd6000;
   endproperty
   a_page90: assert property (p_page90)
      else $error("Page code 90 does not add 6000.");

   // Any response built after a decode with a bad page code must be the
   // error answer with the illegal-number code, whatever software asked.
   property p_bad_page;
      @(posedge hclk) disable iff (!hresetn)
      rsp_go && dec_err_q |=> rsp_w0_q[15:12] == PCWC_RC_ERROR
      && rsp_w3_q == PCWC_ERR_NO_PARAM;
   endproperty
   a_bad_page: assert property (p_bad_page)
      else $error("Undefined page code not answered as error.");

   property p_err_rsp;
      @(posedge hclk) disable iff (!hresetn)
      rsp_go && !dec_err_q && rsp_kind == PCWC_KIND_ERROR
      |=> rsp_w0_q[15:12] == 4'h7 && rsp_w3_q == $past(rsp_err);
   endproperty
   a_err_rsp: assert property (p_err_rsp)
      else $error("Error response code or number is wrong.");

   property p_byte_val;
      @(posedge hclk) disable iff (!hresetn)
      rsp_go && !dec_err_q && rsp_kind == PCWC_KIND_WORD
      && rsp_size == PCWC_SIZE_8
      |=> rsp_w3_q[15:8] == 8'h00 && rsp_w3_q[7:0] == $past(rsp_val_q[7:0]);
   endproperty
   a_byte_val: assert property (p_byte_val)
      else $error("8-bit value not right-justified.");

   property p_dword;
      @(posedge hclk) disable iff (!hresetn)
      rsp_go && !dec_err_q && rsp_kind == PCWC_KIND_DWORD
      |=> rsp_w0_q[15:12] == 4'h2 && {rsp_w2_q, rsp_w3_q} == $past(rsp_val_q);
   endproperty
   a_dword: assert property (p_dword)
      else $error("Double-word response is wrong.");

   property p_value_words;
      @(posedge hclk) disable iff (!hresetn)
      dec_go && id_q[15:12] != 4'h6
      |=> dec_val_q == {$past(vhi_q), $past(vlo_q)};
   endproperty
   a_value_words: assert property (p_value_words)
      else $error("Value words decoded in the wrong order.");

   property p_read_zero;
      @(posedge hclk) disable iff (!hresetn)
      dec_go && id_q[15:12] == 4'h6 |=> dec_val_q == 32'h0 && dec_rd_q;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("Read request value words not ignored.");

   c_read_arr: cover property (@(posedge hclk) disable iff (!hresetn)
      dec_go && id_q[15:12] == 4'h6 && pg_ok);
   c_bad_page: cover property (@(posedge hclk) disable iff (!hresetn)
      dec_go && !pg_ok);
   c_dword: cover property (@(posedge hclk) disable iff (!hresetn)
      rsp_go && rsp_kind == PCWC_KIND_DWORD);
endmodule // pcwc_codec

// file: pcwc_master_model.sv
`timescale 1ns/1ps
// Requester side: packs one parameter request into the four channel words.
module pcwc_master_model
(
   input  wire logic [14:0] pnum,
   input  wire logic [7:0]  sub,
   input  wire logic [3:0]  code,
   input  wire logic [31:0] val,
   input  wire logic        rd,
   output logic      [15:0] id_w,
   output logic      [15:0] idx_w,
   output logic      [15:0] vhi_w,
   output logic      [15:0] vlo_w
);
   logic [14:0] off;
   logic [7:0]  pg;

   // Range 4000 to 5999 has no page code; this model still sends it on page 80 with the number field cut to 11 bits.
   always_comb
   begin
      if (pnum >= 15'd30000) {pg, off} = {8'hf0, 15'd30000};
      else if (pnum >= 15'd20000) {pg, off} = {8'h50, 15'd20000};
      else if (pnum >= 15'd10000) {pg, off} = {8'ha0, 15'd10000};
      else if (pnum >= 15'd8000) {pg, off} = {8'h20, 15'd8000};
      else if (pnum >= 15'd6000) {pg, off} = {8'h90, 15'd6000};
      else if (pnum >= 15'd2000) {pg, off} = {8'h80, 15'd2000};
      else {pg, off} = {8'h00, 15'd0};
   end

   // Word order is identifier, index, high value, low value.
   assign id_w  = {code, 1'b0, 11'(pnum - off)};
   assign idx_w = {pg, sub};
   assign vhi_w = rd ? 16'h0000 : val[31:16];
   assign vlo_w = rd ? 16'h0000 : val[15:0];
endmodule // pcwc_master_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   import pcwc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd;
   logic [31:0] haddr, hwdata, hrdata, val, rdat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [14:0] pnum;
   logic [7:0]  sub;
   logic [3:0]  code;
   logic [15:0] id_w, idx_w, vhi_w, vlo_w;
   int          fail_count, comparisons;
   int          offs [7] = '{0, 2000, 6000, 8000, 10000, 20000, 30000};

   pcwc_codec u_pcwc_codec (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   pcwc_master_model u_pcwc_master_model (.pnum(pnum), .sub(sub),
      .code(code), .val(val), .rd(rd), .id_w(id_w), .idx_w(idx_w),
      .vhi_w(vhi_w), .vlo_w(vlo_w));

   // Free-running bus clock at 20 MHz.
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Waits for hready high at a rising edge and takes the read data at
   // that edge, before the design's flops move on.
   task automatic wait_rdy;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rdat = hrdata;
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'd2;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(rdat, exp);
      check({31'h0, hresp}, 32'h0);
   endtask

   // Loads the model's four words and latches a decode.
   task automatic send(input logic [14:0] p, input logic [7:0] s,
                       input logic [3:0] c, input logic [31:0] v,
                       input logic r);
      pnum = p;
      sub = s;
      code = c;
      val = v;
      rd = r;
      @(posedge hclk);
      xfer(1'b1, PCWC_REQ_ID, {16'h0, id_w});
      xfer(1'b1, PCWC_REQ_IDX, {16'h0, idx_w});
      xfer(1'b1, PCWC_REQ_VHI, {16'h0, vhi_w});
      xfer(1'b1, PCWC_REQ_VLO, {16'h0, vlo_w});
      xfer(1'b1, PCWC_DEC_CMD, 32'h1);
   endtask

   task automatic resp(input logic [1:0] k, input logic [1:0] sz,
                       input logic [7:0] err, input logic [15:0] idx,
                       input logic [3:0] rc, input logic [31:0] w23);
      xfer(1'b1, PCWC_RSP_CMD, {16'h0, err, 4'h0, sz, k});
      rd_chk(PCWC_RSP_W01, {idx, rc, 1'b0, id_w[10:0]});
      rd_chk(PCWC_RSP_W23, w23);
   endtask

   function automatic logic [31:0] dpar(input logic [14:0] p,
      input logic [7:0] s, input logic [3:0] c, input logic conn);
      return {1'b0, conn, c == 4'h7, c == 4'h6, s, c, 1'b0, p};
   endfunction

   // Bounds a hang well beyond the length of the sequence below.
   initial
   begin
      repeat (3000) @(posedge hclk);
      fail_count++;
      $display("FAIL %0t: watchdog expired", $time);
      stop_test;
   end

   initial
   begin
      {hresetn, hsel, hwrite, rd} = 4'h0;
      {haddr, hwdata, val, htrans, hsize} = '0;
      {pnum, sub, code, fail_count, comparisons} = '0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // Every word, the hole at 0x1c among them, reads zero after reset.
      for (int a = 0; a < 48; a += 4)
         rd_chk(8'(a), 32'h0);
      xfer(1'b1, 8'h1c, 32'hffff_ffff);
      rd_chk(8'h1c, 32'h0);
      // Number 1999 above the offset of every page code as an array read.
      foreach (offs[i])
      begin
         send(15'(offs[i] + 1999), 8'(i + 1), 4'h6, 32'h0, 1'b1);
         rd_chk(PCWC_DEC_PAR, dpar(15'(offs[i] + 1999), 8'(i + 1), 4'h6, 1'b0));
         rd_chk(PCWC_DEC_VAL, 32'h0);
      end
      // Undefined page code, then a response that must turn into an error.
      xfer(1'b1, PCWC_REQ_IDX, 32'h1005);
      xfer(1'b1, PCWC_DEC_CMD, 32'h1);
      rd_chk(PCWC_DEC_PAR, {4'h1, 8'h05, 4'h6, 1'b1, 15'h0});
      xfer(1'b1, PCWC_RSP_VAL, 32'h1234_56a5);
      resp(2'h0, 2'h2, 8'h33, 16'h1005, 4'h7, 32'h0);
      // Plain word write, then every response kind and size.
      send(15'd1210, 8'h0, 4'h7, 32'h0000_001a, 1'b0);
      rd_chk(PCWC_DEC_PAR, dpar(15'd1210, 8'h0, 4'h7, 1'b0));
      rd_chk(PCWC_DEC_VAL, 32'h1a);
      resp(2'h0, 2'h0, 8'h0, idx_w, 4'h1, 32'h00a5);
      resp(2'h0, 2'h1, 8'h0, idx_w, 4'h1, 32'h56a5);
      resp(2'h0, 2'h2, 8'h0, idx_w, 4'h2, 32'h1234_56a5);
      resp(2'h1, 2'h0, 8'h0, idx_w, 4'h2, 32'h1234_56a5);
      resp(2'h2, 2'h1, 8'h11, idx_w, 4'h7, 32'h0011);
      // Connector value on an array element.
      send(15'd840, 8'h1, 4'h7, {16'd722, 6'h3f, 10'd2}, 1'b0);
      rd_chk(PCWC_DEC_PAR, dpar(15'd840, 8'h1, 4'h7, 1'b1));
      rd_chk(PCWC_DEC_VAL, {16'd722, 6'h3f, 10'd2});
      stop_test;
   end
endmodule // testbench
